//--- wlcfg_pkg.sv
package wlcfg_pkg;
	////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_LEVEL_LOWER = 6'h1D;
	localparam logic [5:0] IDX_LEVEL_UPPER = 6'h1E;
	localparam logic [5:0] IDX_PULSE_SETUP = 6'h1F;
	localparam logic [7:0] ADDR_LEVEL_LOWER = {IDX_LEVEL_LOWER, 2'b00};
	localparam logic [7:0] ADDR_LEVEL_UPPER = {IDX_LEVEL_UPPER, 2'b00};
	localparam logic [7:0] ADDR_PULSE_SETUP = {IDX_PULSE_SETUP, 2'b00};
	////////////////////////////////////////////////////////////////////////
	// reset values and writable masks
	localparam logic [23:0] RST_LEVEL_LOWER = 24'h000000;
	localparam logic [23:0] RST_LEVEL_UPPER = 24'h000000;
	localparam logic [23:0] RST_PULSE_SETUP = 24'h000000;
	localparam logic [23:0] MASK_LEVEL_LOWER = 24'hFFFFFF;
	localparam logic [23:0] MASK_LEVEL_UPPER = 24'h7FFFFF;
	localparam logic [23:0] MASK_PULSE_SETUP = 24'h00007F;
	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int SINK_DOWNSCALE_OFF_BIT = 22;
	localparam int SOURCE_DOWNSCALE_OFF_BIT = 21;
	localparam int PULSE_TIME_LSB = 4;
	localparam int PULSE_TIME_W = 3;
	localparam int PULSE_GROUP_SIZE = 6;
	localparam int LEVEL_W = 3;
	////////////////////////////////////////////////////////////////////////
	// decoded current selections driven to the analog sources
	localparam logic [2:0] CUR_OFF = 3'h0;
	localparam logic [2:0] CUR_1MA = 3'h1;
	localparam logic [2:0] CUR_2MA = 3'h2;
	localparam logic [2:0] CUR_5MA = 3'h3;
	localparam logic [2:0] CUR_10MA = 3'h4;
	localparam logic [2:0] CUR_15MA = 3'h5;
	////////////////////////////////////////////////////////////////////////
	// pulse time base
	localparam int PULSE_STEP_US = 64;
	localparam int CLK_MHZ = 100;
	localparam logic [15:0] PULSE_STEP_CYC = 16'(PULSE_STEP_US * CLK_MHZ);
	////////////////////////////////////////////////////////////////////////
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- wlcfg_regs.sv
`timescale 1ns/10ps
module wlcfg_regs #(
	parameter int ADDR_W = 8,
	parameter int NUM_IN = 24
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic continuous_mode,
	input wire logic [NUM_IN-1:0] switch_closed,
	input wire logic [NUM_IN-1:0] source_polarity,
	output logic [NUM_IN*3-1:0] wet_current_sel,
	output logic [15:0] pulse_time_cycles,
	output logic [NUM_IN-1:0] pulse_level_high
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [23:0] lower;
		logic [23:0] upper;
		logic [23:0] pulse;
		logic aw_full;
		logic [ADDR_W-1:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [NUM_IN*3-1:0] cur_sel;
		logic [15:0] pulse_cyc;
		logic [NUM_IN-1:0] pulse_hi;
	} wlcfg_state_s;

	wlcfg_state_s st_q;
	wlcfg_state_s st_d;

	////////////////////////////////////////////////////////////////////////
	// which 3-bit slot of {upper, lower} holds the level of input i
	function automatic logic [2:0] wlcfg_level_code(input logic [47:0] regs, input int i);
		logic [3:0] slot;
		slot = 4'h0;
		case (i)
			0, 1: slot = 4'h0;
			2, 3: slot = 4'h1;
			4: slot = 4'h2;
			5: slot = 4'h3;
			6, 7: slot = 4'h4;
			8, 9: slot = 4'h5;
			10: slot = 4'h6;
			11: slot = 4'h7;
			12, 13: slot = 4'h8;
			14, 15: slot = 4'h9;
			16, 17: slot = 4'hA;
			18, 19: slot = 4'hB;
			20, 21: slot = 4'hC;
			22: slot = 4'hD;
			default: slot = 4'hE; // input 23
		endcase
		return regs[slot*3 +: 3];
	endfunction

	function automatic logic [2:0] wlcfg_decode(input logic [2:0] code);
		logic [2:0] cur;
		cur = wlcfg_pkg::CUR_15MA; // 5..7 all max
		case (code)
			3'h0: cur = wlcfg_pkg::CUR_OFF;
			3'h1: cur = wlcfg_pkg::CUR_1MA;
			3'h2: cur = wlcfg_pkg::CUR_2MA;
			3'h3: cur = wlcfg_pkg::CUR_5MA;
			3'h4: cur = wlcfg_pkg::CUR_10MA;
			default: cur = wlcfg_pkg::CUR_15MA;
		endcase
		return cur;
	endfunction

	function automatic logic [23:0] wlcfg_merge(input logic [23:0] old, input logic [31:0] data,
			input logic [3:0] strb, input logic [23:0] mask);
		logic [23:0] res;
		res = old;
		for (int b = 0; b < 3; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res & mask;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [7:0] waddr;
		logic [7:0] raddr;
		logic [2:0] cur;
		logic downscale_off;
		st_d = st_q;
		waddr = 8'(st_q.aw_addr);
		raddr = 8'(s_axi_araddr);
		cur = wlcfg_pkg::CUR_OFF;
		downscale_off = 1'b0;

		// address and data are captured independently, in either order
		if (s_axi_awvalid && st_q.awready) begin
			st_d.aw_full = 1'b1;
			st_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_q.wready) begin
			st_d.w_full = 1'b1;
			st_d.w_data = s_axi_wdata;
			st_d.w_strb = s_axi_wstrb;
		end
		if (st_q.bvalid && s_axi_bready) begin
			st_d.bvalid = 1'b0;
		end
		if (st_q.aw_full && st_q.w_full && !st_q.bvalid) begin
			st_d.aw_full = 1'b0;
			st_d.w_full = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = wlcfg_pkg::RESP_OKAY;
			case ({waddr[7:2], 2'b00})
				wlcfg_pkg::ADDR_LEVEL_LOWER: begin
					st_d.lower = wlcfg_merge(st_q.lower, st_q.w_data, st_q.w_strb, wlcfg_pkg::MASK_LEVEL_LOWER);
				end
				wlcfg_pkg::ADDR_LEVEL_UPPER: begin
					st_d.upper = wlcfg_merge(st_q.upper, st_q.w_data, st_q.w_strb, wlcfg_pkg::MASK_LEVEL_UPPER);
				end
				wlcfg_pkg::ADDR_PULSE_SETUP: begin
					st_d.pulse = wlcfg_merge(st_q.pulse, st_q.w_data, st_q.w_strb, wlcfg_pkg::MASK_PULSE_SETUP);
				end
				default: begin
					st_d.bresp = wlcfg_pkg::RESP_SLVERR;
				end
			endcase
		end
		// one buffered beat per channel; ready drops until the write retires
		st_d.awready = !st_d.aw_full;
		st_d.wready = !st_d.w_full;

		if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_q.arready) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = wlcfg_pkg::RESP_OKAY;
			case ({raddr[7:2], 2'b00})
				wlcfg_pkg::ADDR_LEVEL_LOWER: st_d.rdata = {8'h00, st_q.lower};
				wlcfg_pkg::ADDR_LEVEL_UPPER: st_d.rdata = {8'h00, st_q.upper};
				wlcfg_pkg::ADDR_PULSE_SETUP: st_d.rdata = {8'h00, st_q.pulse};
				default: begin
					st_d.rdata = 32'h00000000;
					st_d.rresp = wlcfg_pkg::RESP_SLVERR;
				end
			endcase
		end
		st_d.arready = !st_d.rvalid;

		////////////////////////////////////////////////////////////////////
		// per-input current selection; down-scaling is only meaningful when
		// a contact is closed, to save power while keeping it wet
		for (int i = 0; i < NUM_IN; i++) begin
			cur = wlcfg_decode(wlcfg_level_code({st_q.upper, st_q.lower}, i));
			downscale_off = source_polarity[i] ? st_q.upper[wlcfg_pkg::SINK_DOWNSCALE_OFF_BIT]
				: st_q.upper[wlcfg_pkg::SOURCE_DOWNSCALE_OFF_BIT];
			if (continuous_mode && switch_closed[i] && !downscale_off
					&& (cur == wlcfg_pkg::CUR_10MA || cur == wlcfg_pkg::CUR_15MA)) begin
				cur = wlcfg_pkg::CUR_2MA;
			end
			st_d.cur_sel[i*3 +: 3] = cur;
			st_d.pulse_hi[i] = st_q.pulse[i / wlcfg_pkg::PULSE_GROUP_SIZE];
		end
		st_d.pulse_cyc = 16'(wlcfg_pkg::PULSE_STEP_CYC
			* (16'(st_q.pulse[wlcfg_pkg::PULSE_TIME_LSB +: wlcfg_pkg::PULSE_TIME_W]) + 16'h0001));
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '0;
			st_q.lower <= wlcfg_pkg::RST_LEVEL_LOWER;
			st_q.upper <= wlcfg_pkg::RST_LEVEL_UPPER;
			st_q.pulse <= wlcfg_pkg::RST_PULSE_SETUP;
			st_q.pulse_cyc <= wlcfg_pkg::PULSE_STEP_CYC;
		end else begin
			st_q <= st_d;
		end
	end

	assign s_axi_awready = st_q.awready;
	assign s_axi_wready = st_q.wready;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_arready = st_q.arready;
	assign s_axi_rvalid = st_q.rvalid;
	assign s_axi_rdata = st_q.rdata;
	assign s_axi_rresp = st_q.rresp;
	assign wet_current_sel = st_q.cur_sel;
	assign pulse_time_cycles = st_q.pulse_cyc;
	assign pulse_level_high = st_q.pulse_hi;
endmodule

//--- wlcfg_checker.sv
`timescale 1ns/10ps
module wlcfg_checker #(
	parameter int NUM_IN = 24
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic continuous_mode,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic [NUM_IN*3-1:0] wet_current_sel,
	input wire logic [15:0] pulse_time_cycles,
	input wire logic [NUM_IN-1:0] pulse_level_high
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_rd_top;
		s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00;
	endproperty
	a_rd_top: assert property (p_rd_top) else $error("read top byte set");
	// outputs must already hold reset values on the first cycle out of reset
	property p_rst_out;
		$rose(aresetn) |-> pulse_time_cycles == 16'h1900 && wet_current_sel == '0 && pulse_level_high == '0;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs not reset");
	property p_time;
		pulse_time_cycles % 16'h1900 == 16'h0000 && pulse_time_cycles inside {[16'h1900:16'hC800]};
	endproperty
	a_time: assert property (p_time) else $error("pulse time off grid");
	property p_group;
		pulse_level_high[5:0] inside {6'h00, 6'h3F} && pulse_level_high[23:18] inside {6'h00, 6'h3F};
	endproperty
	a_group: assert property (p_group) else $error("pulse group split");
	property p_pair;
		!$past(continuous_mode) |-> wet_current_sel[2:0] == wet_current_sel[5:3];
	endproperty
	a_pair: assert property (p_pair) else $error("pair level differs");
	property p_code;
		wet_current_sel[2:0] < 3'h6 && wet_current_sel[71:69] < 3'h6;
	endproperty
	a_code: assert property (p_code) else $error("current code out of range");
endmodule

//--- tb_wetting_current_config_regs.sv
`timescale 1ns/10ps
module tb_wetting_current_config_regs;
	localparam int NUM_IN = 24;
	localparam logic [7:0] LO = wlcfg_pkg::ADDR_LEVEL_LOWER;
	localparam logic [7:0] UP = wlcfg_pkg::ADDR_LEVEL_UPPER;
	localparam logic [7:0] PS = wlcfg_pkg::ADDR_PULSE_SETUP;
	localparam logic [1:0] OK = wlcfg_pkg::RESP_OKAY;
	localparam logic [1:0] ER = wlcfg_pkg::RESP_SLVERR;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic cmode = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [2:0] prot = 3'h0;
	logic [3:0] strb = 4'hF;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [23:0] closed = 24'h0, pol = 24'h0, plh;
	logic [71:0] cur;
	logic [15:0] ptc;
	int mismatches = 0, checks = 0, cyc = 0;
	int exu[12] = '{2, 2, 1, 1, 5, 5, 4, 4, 3, 3, 2, 1};
	wlcfg_regs #(.ADDR_W(8), .NUM_IN(NUM_IN)) wlcfg_regs_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(prot), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .continuous_mode(cmode),
		.switch_closed(closed), .source_polarity(pol), .wet_current_sel(cur), .pulse_time_cycles(ptc),
		.pulse_level_high(plh));
	always #5 aclk = ~aclk;
	////////////////////////////////
	task automatic give_verdict();
		if (mismatches == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask
	function automatic logic [31:0] f(input int i);
		return 32'(cur[3 * i +: 3]);
	endfunction
	function automatic logic [31:0] dec(input int c);
		return 32'((c > 4) ? 5 : c);
	endfunction
	// bready comes one cycle late so the response has to stand idle once
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		strb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b1;
		@(posedge aclk);
		bready <= 1'b0;
		chk("bresp", 32'(er), 32'(bresp));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		// rready stays up between reads so a read that follows at once never drives it twice in one step
		chk("rdata", ed, rdata);
		chk("rresp", 32'(er), 32'(rresp));
	endtask
	////////////////////////////////
	initial begin
		logic [3:0] g;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("time", 32'h1900, 32'(ptc));
		wr(8'h10, 32'hFFFFFFFF, 4'hF, ER);
		rd(LO, 32'h0, OK);
		rd(UP, 32'h0, OK);
		rd(PS, 32'h0, OK);
		rd(8'h00, 32'h0, ER);
		wr(UP, 32'hFFFFFFFF, 4'hF, OK);
		rd(UP, 32'h7FFFFF, OK);
		wr(PS, 32'hFFFFFFFF, 4'hF, OK);
		rd(PS, 32'h7F, OK);
		wr(LO, 32'hFFFFFFFF, 4'h2, OK);
		rd(LO, 32'hFF00, OK);
		for (int c = 0; c < 8; c++) begin
			wr(LO, 32'((c << 6) | ((7 - c) << 3) | c), 4'hF, OK);
			@(posedge aclk);
			chk("in0", dec(c), f(0));
			chk("in1", dec(c), f(1));
			chk("in2", dec(7 - c), f(2));
			chk("in4", dec(c), f(4));
		end
		wr(UP, 32'h05394A, 4'hF, OK);
		@(posedge aclk);
		for (int i = 12; i < 24; i++) chk("upper", 32'(exu[i - 12]), f(i));
		// input 13 is a sink and 12 a source, so each enable is seen alone
		cmode <= 1'b1;
		closed <= 24'hFF7FFF;
		pol <= 24'h002000;
		for (int d = 3; d >= 0; d--) begin
			wr(UP, 32'(d << 21) | 32'hEC, 4'hF, OK);
			@(posedge aclk);
			chk("src", 32'(d[0] ? 4 : 2), f(12));
			chk("sink", 32'(d[1] ? 4 : 2), f(13));
			chk("max", 32'(d[0] ? 5 : 2), f(14));
			chk("open", 32'h5, f(15));
			chk("low", 32'h3, f(16));
		end
		cmode <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("poll", 32'h4, f(12));
		for (int t = 0; t < 8; t++) begin
			g = 4'(t * 3);
			wr(PS, 32'(t * 16) | 32'(g), 4'hF, OK);
			@(posedge aclk);
			chk("time", 32'((t + 1) * 32'h1900), 32'(ptc));
			chk("group", {8'h00, {6{g[3]}}, {6{g[2]}}, {6{g[1]}}, {6{g[0]}}}, 32'(plh));
		end
		give_verdict();
	end
endmodule
bind wlcfg_regs wlcfg_checker #(.NUM_IN(NUM_IN)) wlcfg_checker_inst (.aclk, .aresetn, .continuous_mode,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.wet_current_sel, .pulse_time_cycles, .pulse_level_high);
